// [hdl/etseq_edge.sv]
// Purpose: Synchronise the trigger pin and detect the selected edge.
// Assumes: Pin is asynchronous to clk_sys.
// Notes:   Three stages; the edge is taken where stages two and three differ.
`timescale 1ns/1ps
module etseq_edge (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Pin and selection
    input  wire logic trig_pin,
    input  wire logic rising_sel,
    // Result
    output logic      edge_pulse
);
    import etseq_pkg::*;

    logic [2:0] sync;

    // Three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync <= 3'h7;
        end else begin
            sync <= {sync[1:0], trig_pin};
        end
    end

    // Selected edge as one-cycle pulse
    always_comb begin
        if (rising_sel) begin
            edge_pulse = sync[1] & ~sync[2];
        end else begin
            edge_pulse = ~sync[1] & sync[2];
        end
    end

endmodule

// [hdl/etseq_pkg.sv]
// Purpose: Shared constants and types for the external trigger sequencer.
// Assumes: 100 MHz system clock.
// Notes:   Register map is a small private map over a plain strobe port.
package etseq_pkg;

    // Register offsets (word indices on the plain port)
    localparam logic [3:0] ETSEQ_OFS_CTRL   = 4'h0;
    localparam logic [3:0] ETSEQ_OFS_DELAY  = 4'h1;
    localparam logic [3:0] ETSEQ_OFS_POINTS = 4'h2;
    localparam logic [3:0] ETSEQ_OFS_STATUS = 4'h3;
    localparam logic [3:0] ETSEQ_OFS_ID     = 4'h4;

    // Control field positions
    localparam int ETSEQ_CTRL_SRC_EXT  = 0;
    localparam int ETSEQ_CTRL_PER_PT   = 1;
    localparam int ETSEQ_CTRL_RISING   = 2;
    localparam int ETSEQ_CTRL_POS_ADC  = 3;
    localparam int ETSEQ_CTRL_ARM      = 4;

    // Reset values
    localparam logic [4:0]  ETSEQ_CTRL_RST   = 5'h00;
    localparam logic [15:0] ETSEQ_DELAY_RST  = 16'h0000;
    localparam logic [15:0] ETSEQ_POINTS_RST = 16'h0001;

    // Arbitrary identification value
    localparam logic [31:0] ETSEQ_ID_VALUE   = 32'h0000_5E01;

    // Delay resolution: one count per 100 ns at 100 MHz
    localparam int ETSEQ_CLK_MHZ        = 100;
    localparam int ETSEQ_DELAY_STEP_NS  = 100;
    localparam int ETSEQ_DELAY_STEP_CYC = (ETSEQ_DELAY_STEP_NS * ETSEQ_CLK_MHZ) / 1000;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } etseq_bus_t;

    // Handshake with the sweep engine
    typedef struct packed {
        logic tune_start;
        logic adc_start;
    } etseq_cmd_t;

    typedef enum logic [2:0] {
        ETSEQ_IDLE,
        ETSEQ_WAIT_TRIG,
        ETSEQ_DELAY,
        ETSEQ_TUNE,
        ETSEQ_SAMPLE
    } etseq_state_t;

endpackage

// [hdl/etseq_top.sv]
// Purpose: External trigger gating of a frequency-sweep sequencer.
// Assumes: Sweep engine acknowledges tuning and sampling with one-cycle done pulses.
// Notes:   Registers on a plain strobe port, read data one cycle after the strobe.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module etseq_top (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Register port
    input  wire etseq_pkg::etseq_bus_t bus,
    output logic [31:0]              rdata,
    // Trigger pin and sweep engine
    input  wire logic                trig_pin,
    input  wire logic                tune_done,
    input  wire logic                adc_done,
    output etseq_pkg::etseq_cmd_t    cmd,
    output logic                     waiting,
    output logic                     sweep_done
);
    import etseq_pkg::*;

    logic [4:0]   ctrl;
    logic [15:0]  delay_val;
    logic [15:0]  num_points;
    logic [15:0]  point_idx;
    logic [15:0]  dly_cnt;
    logic [7:0]   step_cnt;
    logic         trig_edge;
    logic         trig_ok;
    logic         after_tune;
    logic         arm_pulse;
    etseq_state_t state;

    wire src_ext = ctrl[ETSEQ_CTRL_SRC_EXT];
    wire per_pt  = ctrl[ETSEQ_CTRL_PER_PT];
    wire pos_adc = ctrl[ETSEQ_CTRL_POS_ADC];
    wire last_pt = (point_idx >= num_points - 16'h0001);

    // Edge detection on the synchronised pin
    etseq_edge u_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .trig_pin   (trig_pin),
        .rising_sel (ctrl[ETSEQ_CTRL_RISING]),
        .edge_pulse (trig_edge)
    );

    // Accepted only from the external source and only while waiting
    assign trig_ok = trig_edge & src_ext & (state == ETSEQ_WAIT_TRIG);

    // Control and configuration registers; arm bit is self-clearing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl       <= ETSEQ_CTRL_RST;
            delay_val  <= ETSEQ_DELAY_RST;
            num_points <= ETSEQ_POINTS_RST;
            arm_pulse  <= 1'b0;
        end else begin
            arm_pulse <= 1'b0;
            if (bus.wr) begin
                case (bus.addr)
                    ETSEQ_OFS_CTRL: begin
                        ctrl      <= bus.wdata[4:0] & 5'h0F;
                        arm_pulse <= bus.wdata[ETSEQ_CTRL_ARM];
                    end
                    ETSEQ_OFS_DELAY:  delay_val <= bus.wdata[15:0];
                    ETSEQ_OFS_POINTS: num_points <= (bus.wdata[15:0] == 16'h0000) ?
                                                    16'h0001 : bus.wdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            case (bus.addr)
                ETSEQ_OFS_CTRL:   rdata <= {27'h0, ctrl};
                ETSEQ_OFS_DELAY:  rdata <= {16'h0, delay_val};
                ETSEQ_OFS_POINTS: rdata <= {16'h0, num_points};
                ETSEQ_OFS_STATUS: rdata <= {13'h0, state, point_idx};
                ETSEQ_OFS_ID:     rdata <= ETSEQ_ID_VALUE;
                default:          rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // Sweep sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state      <= ETSEQ_IDLE;
            point_idx  <= 16'h0000;
            dly_cnt    <= 16'h0000;
            step_cnt   <= 8'h00;
            after_tune <= 1'b0;
            cmd        <= '0;
            waiting    <= 1'b0;
            sweep_done <= 1'b0;
        end else begin
            cmd        <= '0;
            sweep_done <= 1'b0;
            case (state)
                ETSEQ_IDLE: begin
                    if (arm_pulse) begin
                        point_idx <= 16'h0000;
                        after_tune <= 1'b0;
                        if (pos_adc) begin
                            state          <= ETSEQ_TUNE;
                            cmd.tune_start <= 1'b1;
                        end else begin
                            state   <= ETSEQ_WAIT_TRIG;
                            waiting <= 1'b1;
                        end
                    end
                end
                ETSEQ_WAIT_TRIG: begin
                    if (trig_ok) begin
                        waiting  <= 1'b0;
                        dly_cnt  <= delay_val;
                        step_cnt <= 8'(ETSEQ_DELAY_STEP_CYC - 1);
                        state    <= ETSEQ_DELAY;
                    end
                end
                ETSEQ_DELAY: begin
                    if (dly_cnt == 16'h0000) begin
                        if (after_tune) begin
                            state         <= ETSEQ_SAMPLE;
                            cmd.adc_start <= 1'b1;
                        end else begin
                            state          <= ETSEQ_TUNE;
                            cmd.tune_start <= 1'b1;
                        end
                    end else if (step_cnt == 8'h00) begin
                        step_cnt <= 8'(ETSEQ_DELAY_STEP_CYC - 1);
                        dly_cnt  <= dly_cnt - 16'h0001;
                    end else begin
                        step_cnt <= step_cnt - 8'h01;
                    end
                end
                ETSEQ_TUNE: begin
                    if (tune_done) begin
                        if (pos_adc && (per_pt || point_idx == 16'h0000)) begin
                            after_tune <= 1'b1;
                            waiting    <= 1'b1;
                            state      <= ETSEQ_WAIT_TRIG;
                        end else begin
                            state         <= ETSEQ_SAMPLE;
                            cmd.adc_start <= 1'b1;
                        end
                    end
                end
                ETSEQ_SAMPLE: begin
                    if (adc_done) begin
                        after_tune <= 1'b0;
                        if (last_pt) begin
                            point_idx  <= 16'h0000;
                            sweep_done <= 1'b1;
                            state      <= ETSEQ_IDLE;
                        end else begin
                            point_idx <= point_idx + 16'h0001;
                            if (per_pt) begin
                                if (pos_adc) begin
                                    state          <= ETSEQ_TUNE;
                                    cmd.tune_start <= 1'b1;
                                end else begin
                                    state   <= ETSEQ_WAIT_TRIG;
                                    waiting <= 1'b1;
                                end
                            end else begin
                                state          <= ETSEQ_TUNE;
                                cmd.tune_start <= 1'b1;
                            end
                        end
                    end
                end
                default: state <= ETSEQ_IDLE;
            endcase
        end
    end

endmodule

// [testbench/etseq_asserts.sv]
// Purpose: Port-level checks for the trigger sequencer.
// Assumes: Bound to etseq_top; one clock domain.
// Notes:   Delay bound covers the largest delay the bench programs.
`timescale 1ns/1ps
module etseq_asserts (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // Register port
    input wire etseq_pkg::etseq_bus_t bus,
    input wire logic [31:0]           rdata,
    // Pin and sweep engine
    input wire logic                  trig_pin,
    input wire logic                  tune_done,
    input wire logic                  adc_done,
    input wire etseq_pkg::etseq_cmd_t cmd,
    input wire logic                  waiting,
    input wire logic                  sweep_done
);
    import etseq_pkg::*;
    localparam int DLY_MAX = 40;
    logic tuned;
    // Remember that the current point has been tuned
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) tuned <= 1'b0;
        else if (tune_done) tuned <= 1'b1;
        else if (cmd.adc_start) tuned <= 1'b0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_tune_first: assert property (cmd.adc_start |-> tuned)
        else $error("sampling began before tuning");
    a_cmd_apart: assert property (!(cmd.tune_start && cmd.adc_start))
        else $error("tune and sample started together");
    a_tune_pulse: assert property (cmd.tune_start |=> !cmd.tune_start)
        else $error("tune start longer than one cycle");
    a_tune_next: assert property (tune_done |-> ##[1:2] (cmd.adc_start || waiting))
        else $error("nothing followed tuning");
    a_wait_quiet: assert property (waiting |-> !cmd.tune_start && !cmd.adc_start)
        else $error("start issued while waiting");
    // Bound covers the largest delay the bench programs
    a_delay_bound: assert property ($fell(waiting) |-> ##[1:DLY_MAX]
        (cmd.tune_start || cmd.adc_start))
        else $error("no start after accepted trigger");
    a_done_cause: assert property (sweep_done |-> $past(adc_done))
        else $error("sweep done without sampling");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside read cycle");
    c_sweep: cover property (sweep_done);
    c_accept: cover property ($fell(waiting));
    c_tune_wait: cover property (tune_done ##[1:2] waiting);
endmodule

// [testbench/etseq_top_tb_top.sv]
// Purpose: Self-checking bench for the trigger sequencer.
// Assumes: Sweep engine finishes every start one cycle later.
// Notes:   Each test begins from a fresh reset.
`timescale 1ns/1ps
module etseq_top_tb_top;
    import etseq_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, idle_lvl = 1'b1, shot = 1'b0;
    logic        tune_done = 1'b0, adc_done = 1'b0, trig_pin, waiting, sweep_done;
    etseq_bus_t  bus = '0;
    etseq_cmd_t  cmd;
    logic [31:0] rdata;
    int          mismatches = 0, checked = 0, n_tune, n_adc, lat;
    etseq_top dut_u (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
        .trig_pin(trig_pin), .tune_done(tune_done), .adc_done(adc_done), .cmd(cmd),
        .waiting(waiting), .sweep_done(sweep_done));
    etseq_trig_src src_u (.clk_sys(clk_sys), .idle_lvl(idle_lvl), .shot(shot),
        .trig_pin(trig_pin));
    // Clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Sweep engine stand-in
    always @(posedge clk_sys) begin
        tune_done <= cmd.tune_start;
        adc_done <= cmd.adc_start;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reset_dut;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys);
        bus <= '0;
        @(negedge clk_sys);
        chk(rdata, exp);
    endtask
    task automatic fire;
        @(posedge clk_sys);
        shot <= 1'b1;
        @(posedge clk_sys);
        shot <= 1'b0;
    endtask
    // Count starts until sweep end, or until a new wait when asked
    task automatic run(input bit stop_w);
        bit gone;
        gone = 1'b0;
        n_tune = 0;
        n_adc = 0;
        repeat (200) begin
            @(negedge clk_sys);
            n_tune += int'(cmd.tune_start === 1'b1);
            n_adc += int'(cmd.adc_start === 1'b1);
            if (sweep_done === 1'b1 || (stop_w && gone && waiting === 1'b1)) break;
            if (waiting !== 1'b1) gone = 1'b1;
        end
    endtask
    task automatic t_regs;
        reset_dut;
        rd_chk(ETSEQ_OFS_CTRL, 32'h0);
        rd_chk(ETSEQ_OFS_DELAY, 32'h0);
        rd_chk(ETSEQ_OFS_POINTS, 32'h1);
        rd_chk(ETSEQ_OFS_ID, ETSEQ_ID_VALUE);
        rd_chk(4'hF, 32'h0);
        rd_chk(ETSEQ_OFS_STATUS, 32'h0);
        wr(ETSEQ_OFS_CTRL, 32'h1E);
        rd_chk(ETSEQ_OFS_CTRL, 32'hE);
        wr(ETSEQ_OFS_POINTS, 32'h0);
        rd_chk(ETSEQ_OFS_POINTS, 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_off;
        reset_dut;
        wr(ETSEQ_OFS_CTRL, 32'h10);
        fire;
        run(1'b0);
        chk(n_tune, 0);
        $display("t_off done");
    endtask
    task automatic t_cycle;
        reset_dut;
        wr(ETSEQ_OFS_POINTS, 32'h3);
        wr(ETSEQ_OFS_CTRL, 32'h11);
        run(1'b1);
        chk(waiting, 1'b1);
        fire;
        run(1'b1);
        chk(n_tune, 3);
        chk(n_adc, 3);
        chk(sweep_done, 1'b1);
        $display("t_cycle done");
    endtask
    task automatic t_point;
        reset_dut;
        wr(ETSEQ_OFS_POINTS, 32'h2);
        wr(ETSEQ_OFS_CTRL, 32'h1F);
        run(1'b1);
        chk(n_tune, 1);
        chk(n_adc, 0);
        fire;
        repeat (5) @(negedge clk_sys);
        chk(waiting, 1'b1);
        run(1'b1);
        chk(n_adc, 1);
        chk(n_tune, 1);
        fire;
        run(1'b1);
        chk(n_adc, 1);
        chk(sweep_done, 1'b1);
        $display("t_point done");
    endtask
    task automatic t_delay;
        for (int d = 0; d < 4; d += 3) begin
            reset_dut;
            wr(ETSEQ_OFS_DELAY, 32'(d));
            wr(ETSEQ_OFS_CTRL, 32'h11);
            run(1'b1);
            fire;
            repeat (40) begin
                @(negedge clk_sys);
                if (waiting === 1'b0) break;
            end
            lat = 0;
            while (cmd.tune_start !== 1'b1 && lat < 100) begin
                @(negedge clk_sys);
                lat++;
            end
            chk(lat, d * 10 + 1);
        end
        $display("t_delay done");
    endtask
    // Main sequence
    initial begin
        t_regs;
        t_off;
        t_cycle;
        t_point;
        t_delay;
        close_out;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out;
    end
endmodule
bind etseq_top etseq_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .trig_pin(trig_pin), .tune_done(tune_done), .adc_done(adc_done), .cmd(cmd),
    .waiting(waiting), .sweep_done(sweep_done));

// [testbench/etseq_trig_src.sv]
// Purpose: External gear driving the trigger pin.
// Assumes: The gear always drives the pin.
// Notes:   A shot flips the pin for four cycles, then restores it.
`timescale 1ns/1ps
module etseq_trig_src (
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic idle_lvl,
    input wire logic shot,
    // Pin
    output logic     trig_pin
);
    logic [2:0] cnt = 3'h0;
    // Count the flipped span of one shot
    always_ff @(posedge clk_sys) begin
        if (shot) cnt <= 3'h4;
        else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
    assign trig_pin = (cnt != 3'h0) ? !idle_lvl : idle_lvl;
endmodule
